// ==== verilog/hps_pkg.sv ====
package hps_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing.
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned MATE_WAIT_MS    = 250;
    localparam int unsigned UNMATE_LIMIT_MS = 1000;
    localparam int unsigned IO_RESUME_MS    = 200;
    localparam int unsigned MATE_WAIT_CYC   = (CLK_HZ / 1000) * MATE_WAIT_MS;
    localparam int unsigned IO_RESUME_CYC   = (CLK_HZ / 1000) * IO_RESUME_MS;
    localparam int unsigned UNMATE_LIM_CYC  = (CLK_HZ / 1000) * UNMATE_LIMIT_MS;

    ////////////////////////////////////////////////////////////////////////////
    // Strap and filter layout.
    localparam int unsigned ADDR_W          = 4;
    localparam int unsigned ADDR_HI_BIT     = 3;
    localparam int unsigned FILT_LEN        = 4;
    localparam int unsigned CNT_W           = 24;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [3:0]  ADDR_RST        = 4'h0;
    localparam logic [1:0]  MOTOR_RST       = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        HPS_ST_UNMATED = 3'b000,
        HPS_ST_SETTLE  = 3'b001,
        HPS_ST_QUIET   = 3'b011,
        HPS_ST_ACTIVE  = 3'b010,
        HPS_ST_UNMATE  = 3'b110,
        HPS_ST_MODECHG = 3'b111
    } hps_state_t;

endpackage

// ==== verilog/hps_sync_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module hps_sync_filter #(
    parameter int unsigned W   = 1,
    parameter int unsigned LEN = 4
) (
    // Clock and reset.
    input  wire logic         clk_sys_i,
    input  wire logic         resetn_i,
    // Raw and filtered levels.
    input  wire logic [W-1:0] raw_i,
    input  wire logic [W-1:0] rst_val_i,
    output logic      [W-1:0] level_o
);

    typedef struct packed {
        logic [W-1:0]   s1;
        logic [W-1:0]   s2;
        logic [W-1:0]   cand;
        logic [7:0]     cnt;
        logic [W-1:0]   lvl;
        logic           init;
    } hps_flt_t;

    hps_flt_t st_r;
    hps_flt_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser, then a run-length filter on the second flop.
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = raw_i;
        st_nxt.s2 = st_r.s1;
        if (!st_r.init) begin
            st_nxt.lvl  = rst_val_i;
            st_nxt.cand = rst_val_i;
            st_nxt.init = 1'b1;
        end else if (st_r.s2 != st_r.cand) begin
            st_nxt.cand = st_r.s2;
            st_nxt.cnt  = 8'h01;
        end else if (st_r.cnt < 8'(LEN)) begin
            st_nxt.cnt = st_r.cnt + 8'h01;
        end else begin
            st_nxt.lvl = st_r.cand;  // RL16
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Until the first cycle after reset has loaded the filter, show the idle level.
    assign level_o = st_r.init ? st_r.lvl : rst_val_i;

endmodule
`default_nettype wire

// ==== verilog/hps_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module hps_timer #(
    parameter int unsigned CW = 24
) (
    // Clock and reset.
    input  wire logic          clk_sys_i,
    input  wire logic          resetn_i,
    // Control.
    input  wire logic          start_i,
    input  wire logic          stop_i,
    input  wire logic [CW-1:0] load_i,
    output logic               done_o
);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          run;
        logic          done;
    } hps_tmr_t;

    hps_tmr_t st_r;
    hps_tmr_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Down counter; done is a one-cycle pulse when the count expires.
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (stop_i) begin
            st_nxt.run = 1'b0;
        end else if (start_i) begin
            st_nxt.cnt = load_i;
            st_nxt.run = 1'b1;
        end else if (st_r.run) begin
            if (st_r.cnt <= CW'(1)) begin
                st_nxt.run  = 1'b0;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt - CW'(1);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done_o = st_r.done;

endmodule
`default_nettype wire

// ==== verilog/hps_sequencer.sv ====
// Function
// RL1: Ground on top strap adds eight.
// RL2: Address from four straps, weights 1,2,4,8.
// RL3: Open presence line means not mated.
// RL4: Ground presence line flags partially mated.
// RL5: Power-on 250 ms after mate; sample straps.
// RL6: Detect open presence within one second.
// RL7: On unmate, optional spin-down and cache flush.
// RL8: Backplane grounds presence when secondary mated.
// RL9: Enclosure may open presence to warn removal.
// RL10: Initiator holds bus reset through hot-plug.
// RL11: Quiesce all I/O when none permitted.
// RL12: Quiesce own I/O before removal.
// RL13: Resume I/O no sooner than 200 ms.
// RL14: Bus contacts high-impedance until transceivers enabled.
// RL15: Mode-changing plug event is transceiver reset.
// RL16: Synchronise and filter presence and straps.
`timescale 1ns/1ps
`default_nettype none
module hps_sequencer
    import hps_pkg::*;
#(
    parameter int unsigned MATE_CYC   = hps_pkg::MATE_WAIT_CYC,
    parameter int unsigned RESUME_CYC = hps_pkg::IO_RESUME_CYC,
    parameter bit          WIDE_BUS   = 1'b1,
    parameter bit          UNMATE_DET = 1'b1
) (
    // Clock and reset.
    input  wire logic                         clk_sys_i,
    input  wire logic                         resetn_i,
    // Connector pins, high is open, low is ground.
    input  wire logic                         mated_primary_i,
    input  wire logic [hps_pkg::ADDR_W-1:0]   address_select_straps_i,
    input  wire logic                         dlyd_start_strap_i,
    input  wire logic                         rmt_start_strap_i,
    // Device-side controls.
    input  wire logic                         io_idle_i,
    input  wire logic                         xcvr_ready_i,
    input  wire logic                         bus_mode_changed_i,
    input  wire logic                         spin_down_en_i,
    input  wire logic                         flush_en_i,
    // Status and sequencing outputs.
    output logic                              mated_o,
    output logic                              power_on_start_o,
    output logic [hps_pkg::ADDR_W-1:0]        bus_address_o,
    output logic                              address_valid_o,
    output logic [1:0]                        motor_mode_o,
    output logic                              io_enable_o,
    output logic                              quiesce_req_o,
    output logic                              spin_down_req_o,
    output logic                              flush_req_o,
    output logic                              unmate_flag_o,
    output logic                              xcvr_oe_o,
    output logic                              mode_change_reset_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Synchronised and filtered pins.
    logic                mated_flt;
    logic [ADDR_W-1:0]   straps_flt;
    logic [1:0]          motor_flt;
    logic                mate_done;
    logic                resume_done;
    logic                mate_start;
    logic                resume_start;
    logic                tmr_stop;

    hps_sync_filter #(
        .W   (1),
        .LEN (FILT_LEN)
    ) u_mate_flt (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .raw_i     (mated_primary_i),
        .rst_val_i (1'b1),
        .level_o   (mated_flt)
    );

    hps_sync_filter #(
        .W   (ADDR_W + 2),
        .LEN (FILT_LEN)
    ) u_strap_flt (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .raw_i     ({rmt_start_strap_i, dlyd_start_strap_i, address_select_straps_i}),
        .rst_val_i ({(ADDR_W + 2){1'b1}}),
        .level_o   ({motor_flt, straps_flt})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Settle and resume timers.
    hps_timer #(
        .CW (CNT_W)
    ) u_mate_tmr (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .start_i   (mate_start),
        .stop_i    (tmr_stop),
        .load_i    (CNT_W'(MATE_CYC)),
        .done_o    (mate_done)
    );

    hps_timer #(
        .CW (CNT_W)
    ) u_resume_tmr (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .start_i   (resume_start),
        .stop_i    (tmr_stop),
        .load_i    (CNT_W'(RESUME_CYC)),
        .done_o    (resume_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state.
    typedef struct packed {
        hps_state_t        state;
        logic              mated;
        logic              pon;
        logic [ADDR_W-1:0] addr;
        logic              addr_vld;
        logic [1:0]        motor;
        logic              io_en;
        logic              quiesce;
        logic              spin;
        logic              flush;
        logic              unmate;
        logic              oe;
        logic              mcr;
        logic              ret_active;
    } hps_seq_t;

    hps_seq_t st_r;
    hps_seq_t st_nxt;

    logic              present;
    logic [ADDR_W-1:0] decoded;

    ////////////////////////////////////////////////////////////////////////////
    // Presence and address decode; a grounded strap reads as one.
    always_comb begin
        present = ~mated_flt;  // RL3 RL4
        decoded = ~straps_flt;  // RL2
        if (!WIDE_BUS) begin
            decoded[ADDR_HI_BIT] = 1'b0;  // RL1
        end
    end

    assign mate_start   = (st_r.state == HPS_ST_UNMATED) && present;
    assign resume_start = (st_r.state == HPS_ST_SETTLE) && mate_done;
    assign tmr_stop     = (st_r.state != HPS_ST_UNMATED) && !present;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.pon   = 1'b0;
        st_nxt.mcr   = 1'b0;
        st_nxt.mated = present;  // RL4
        unique case (st_r.state)
            HPS_ST_UNMATED: begin
                st_nxt.io_en  = 1'b0;
                st_nxt.oe     = 1'b0;  // RL14
                st_nxt.unmate = 1'b0;
                if (present) begin
                    st_nxt.state = HPS_ST_SETTLE;  // RL5
                end
            end
            HPS_ST_SETTLE: begin
                if (!present) begin
                    st_nxt.state = HPS_ST_UNMATED;
                end else if (mate_done) begin
                    st_nxt.pon      = 1'b1;  // RL5
                    st_nxt.addr     = decoded;  // RL1 RL2
                    st_nxt.addr_vld = 1'b1;
                    st_nxt.motor    = motor_flt;  // RL5
                    st_nxt.state    = HPS_ST_QUIET;
                end
            end
            HPS_ST_QUIET: begin
                if (!present) begin
                    st_nxt.state = HPS_ST_UNMATE;
                end else if (resume_done) begin
                    st_nxt.state = HPS_ST_ACTIVE;  // RL13
                end
            end
            HPS_ST_ACTIVE: begin
                st_nxt.oe    = xcvr_ready_i;  // RL14
                st_nxt.io_en = xcvr_ready_i;  // RL13
                if (bus_mode_changed_i) begin
                    st_nxt.mcr   = 1'b1;  // RL15
                    st_nxt.io_en = 1'b0;
                    st_nxt.state = HPS_ST_MODECHG;
                end else if (!present && UNMATE_DET) begin
                    st_nxt.unmate  = 1'b1;  // RL6
                    st_nxt.quiesce = 1'b1;  // RL12
                    st_nxt.spin    = spin_down_en_i;  // RL7
                    st_nxt.flush   = flush_en_i;  // RL7
                    st_nxt.io_en   = 1'b0;
                    st_nxt.state   = HPS_ST_UNMATE;
                end
            end
            HPS_ST_UNMATE: begin
                st_nxt.io_en = 1'b0;
                if (present) begin
                    st_nxt.state = HPS_ST_UNMATED;
                end else if (io_idle_i) begin
                    st_nxt.quiesce = 1'b0;
                    st_nxt.oe      = 1'b0;  // RL14
                end
                if (present) begin
                    st_nxt.quiesce  = 1'b0;
                    st_nxt.spin     = 1'b0;
                    st_nxt.flush    = 1'b0;
                    st_nxt.addr_vld = 1'b0;
                end
            end
            HPS_ST_MODECHG: begin
                st_nxt.state = HPS_ST_ACTIVE;
            end
            default: begin
                st_nxt.state = HPS_ST_UNMATED;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r       <= '0;
            st_r.state <= HPS_ST_UNMATED;
            st_r.addr  <= ADDR_RST;
            st_r.motor <= MOTOR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register.
    assign mated_o             = st_r.mated;
    assign power_on_start_o    = st_r.pon;
    assign bus_address_o       = st_r.addr;
    assign address_valid_o     = st_r.addr_vld;
    assign motor_mode_o        = st_r.motor;
    assign io_enable_o         = st_r.io_en;
    assign quiesce_req_o       = st_r.quiesce;
    assign spin_down_req_o     = st_r.spin;
    assign flush_req_o         = st_r.flush;
    assign unmate_flag_o       = st_r.unmate;
    assign xcvr_oe_o           = st_r.oe;
    assign mode_change_reset_o = st_r.mcr;

endmodule
`default_nettype wire

// ==== bench/hps_backplane_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Backplane and enclosure side: presence line and wired straps.
module hps_backplane_model (
    // Seating and enclosure control.
    input  wire logic       seat_i,
    input  wire logic       warn_i,
    input  wire logic [3:0] addr_cfg_i,
    input  wire logic [1:0] motor_cfg_i,
    // Connector pins, high is open.
    output logic            mated_primary_o,
    output logic [3:0]      straps_o,
    output logic            dlyd_o,
    output logic            rmt_o
);
    // Presence is grounded only while seated and no removal warning stands.
    assign mated_primary_o = !(seat_i && !warn_i);
    // An unseated drive sees every strap at the open level.
    assign straps_o = seat_i ? addr_cfg_i : 4'hf;
    assign {rmt_o, dlyd_o} = seat_i ? motor_cfg_i : 2'h3;
endmodule
`default_nettype wire

// ==== bench/hps_seq_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module hps_seq_properties
    import hps_pkg::*;
#(
    parameter int unsigned MATE_CYC   = 20,
    parameter int unsigned RESUME_CYC = 16,
    parameter bit          WIDE_BUS   = 1'b1
) (
    // Clock and reset.
    input wire logic                       clk_sys_i,
    input wire logic                       resetn_i,
    // Watched inputs.
    input wire logic                       mated_primary_i,
    input wire logic [hps_pkg::ADDR_W-1:0] address_select_straps_i,
    input wire logic                       xcvr_ready_i,
    input wire logic                       bus_mode_changed_i,
    input wire logic                       spin_down_en_i,
    input wire logic                       flush_en_i,
    // Watched outputs.
    input wire logic                       mated_o,
    input wire logic                       power_on_start_o,
    input wire logic [hps_pkg::ADDR_W-1:0] bus_address_o,
    input wire logic                       address_valid_o,
    input wire logic                       io_enable_o,
    input wire logic                       quiesce_req_o,
    input wire logic                       spin_down_req_o,
    input wire logic                       flush_req_o,
    input wire logic                       unmate_flag_o,
    input wire logic                       xcvr_oe_o,
    input wire logic                       mode_change_reset_o
);
    import hps_pkg::*;
    logic [15:0] open_cnt;
    logic [15:0] gnd_cnt;
    logic [15:0] mate_cnt;
    logic [15:0] since_cnt;
    function automatic logic [15:0] inc(input logic [15:0] c);
        return (c == 16'hffff) ? c : c + 16'h0001;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Counters of pin levels, mated time and time since power-on start.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            open_cnt  <= 16'h0000;
            gnd_cnt   <= 16'h0000;
            mate_cnt  <= 16'h0000;
            since_cnt <= 16'h0000;
        end else begin
            open_cnt  <= mated_primary_i ? inc(open_cnt) : 16'h0000;
            gnd_cnt   <= mated_primary_i ? 16'h0000 : inc(gnd_cnt);
            mate_cnt  <= mated_o ? inc(mate_cnt) : 16'h0000;
            since_cnt <= power_on_start_o ? 16'h0000 : inc(since_cnt);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    pres_open_a: assert property (open_cnt >= 12 |-> !mated_o)
        else $error("presence open but mated shown");
    pres_gnd_a: assert property (gnd_cnt >= 12 |-> mated_o)
        else $error("presence grounded but not mated");
    mate_wait_a: assert property (power_on_start_o |-> mate_cnt >= MATE_CYC - 1)
        else $error("power-on start too early");
    start_pulse_a: assert property (power_on_start_o |=> !power_on_start_o)
        else $error("power-on start longer than one cycle");
    addr_decode_a: assert property (power_on_start_o |=> address_valid_o &&
        bus_address_o == (WIDE_BUS ? ~address_select_straps_i
                                   : {1'h0, ~address_select_straps_i[2:0]}))
        else $error("bus address decode wrong");
    unmate_det_a: assert property ($rose(mated_primary_i) && io_enable_o
        |-> ##[1:20] unmate_flag_o)
        else $error("unmate not detected in time");
    opt_actions_a: assert property ($rose(unmate_flag_o) |-> ##[0:1]
        (spin_down_req_o == spin_down_en_i && flush_req_o == flush_en_i))
        else $error("spin-down or flush request wrong");
    own_quiesce_a: assert property (quiesce_req_o |-> !io_enable_o)
        else $error("io enabled while quiescing");
    resume_wait_a: assert property ($rose(io_enable_o) |-> since_cnt >= RESUME_CYC)
        else $error("io resumed too early");
    bus_hiz_a: assert property ($rose(xcvr_oe_o) |-> $past(xcvr_ready_i) && address_valid_o)
        else $error("contacts driven before transceivers ready");
    mode_rst_a: assert property ($rose(bus_mode_changed_i) && io_enable_o
        |-> ##[1:4] mode_change_reset_o)
        else $error("mode change reset missing");
endmodule
bind hps_sequencer hps_seq_properties #(
    .MATE_CYC(MATE_CYC), .RESUME_CYC(RESUME_CYC), .WIDE_BUS(WIDE_BUS)
) hps_seq_properties_inst (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .mated_primary_i(mated_primary_i),
    .address_select_straps_i(address_select_straps_i), .xcvr_ready_i(xcvr_ready_i),
    .bus_mode_changed_i(bus_mode_changed_i), .spin_down_en_i(spin_down_en_i),
    .flush_en_i(flush_en_i), .mated_o(mated_o), .power_on_start_o(power_on_start_o),
    .bus_address_o(bus_address_o), .address_valid_o(address_valid_o),
    .io_enable_o(io_enable_o), .quiesce_req_o(quiesce_req_o),
    .spin_down_req_o(spin_down_req_o), .flush_req_o(flush_req_o),
    .unmate_flag_o(unmate_flag_o), .xcvr_oe_o(xcvr_oe_o),
    .mode_change_reset_o(mode_change_reset_o)
);
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hps_pkg::*;
    localparam int MATE   = 20;
    localparam int RESUME = 16;
    logic       clk_sys_i = 1'b0;
    logic       resetn_i = 1'b0;
    logic       seat = 1'b0;
    logic       warn = 1'b0;
    logic [3:0] addr_cfg = 4'hf;
    logic [1:0] motor_cfg = 2'h3;
    logic       mated_primary;
    logic [3:0] straps;
    logic       dlyd;
    logic       rmt;
    logic       io_idle = 1'b0;
    logic       xcvr_ready = 1'b0;
    logic       mode_chg = 1'b0;
    logic       spin_en = 1'b0;
    logic       flush_en = 1'b0;
    logic       mated_o, power_on_start_o, address_valid_o, io_enable_o, quiesce_req_o;
    logic       spin_down_req_o, flush_req_o, unmate_flag_o, xcvr_oe_o, mode_change_reset_o;
    logic [3:0] bus_address_o;
    logic [1:0] motor_mode_o;
    int         n_errors = 0;
    int         n_compared = 0;
    int         cyc = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    hps_backplane_model hps_backplane_model_inst (
        .seat_i(seat), .warn_i(warn), .addr_cfg_i(addr_cfg), .motor_cfg_i(motor_cfg),
        .mated_primary_o(mated_primary), .straps_o(straps), .dlyd_o(dlyd), .rmt_o(rmt));
    hps_sequencer #(.MATE_CYC(MATE), .RESUME_CYC(RESUME)) hps_sequencer_inst (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .mated_primary_i(mated_primary),
        .address_select_straps_i(straps), .dlyd_start_strap_i(dlyd),
        .rmt_start_strap_i(rmt), .io_idle_i(io_idle), .xcvr_ready_i(xcvr_ready),
        .bus_mode_changed_i(mode_chg), .spin_down_en_i(spin_en), .flush_en_i(flush_en),
        .mated_o(mated_o), .power_on_start_o(power_on_start_o),
        .bus_address_o(bus_address_o), .address_valid_o(address_valid_o),
        .motor_mode_o(motor_mode_o), .io_enable_o(io_enable_o),
        .quiesce_req_o(quiesce_req_o), .spin_down_req_o(spin_down_req_o),
        .flush_req_o(flush_req_o), .unmate_flag_o(unmate_flag_o), .xcvr_oe_o(xcvr_oe_o),
        .mode_change_reset_o(mode_change_reset_o));
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // A short grounding of presence must not count as mating.
    task automatic t_glitch();
        seat = 1'b1;
        step(3);
        seat = 1'b0;
        step(15);
        chk_bit(mated_o, 1'b0);
        chk_bit(xcvr_oe_o, 1'b0);
    endtask
    // Seat the drive, then follow power-on start and the resume interval.
    task automatic t_insert(input logic [3:0] s, input logic [1:0] m);
        int n;
        int k;
        int j;
        addr_cfg = s;
        motor_cfg = m;
        xcvr_ready = 1'b1;
        seat = 1'b1;
        for (n = 0; n < 40 && mated_o !== 1'b1; n++) step(1);
        chk_bit(mated_o, 1'b1);
        for (k = n; k < 200 && power_on_start_o !== 1'b1; k++) step(1);
        chk_bit(k - n >= MATE && k - n <= MATE + 2, 1'b1);
        step(1);
        chk_val(bus_address_o, ~s);
        chk_val({2'h0, motor_mode_o}, {2'h0, m});
        chk_bit(unmate_flag_o, 1'b0);
        chk_bit(xcvr_oe_o, 1'b0);
        for (j = 0; j < 100 && io_enable_o !== 1'b1; j++) step(1);
        chk_bit(j >= RESUME - 1 && j <= RESUME + 3, 1'b1);
        chk_bit(xcvr_oe_o, 1'b1);
    endtask
    // A bus mode change while active gives a transceiver reset pulse.
    task automatic t_mode();
        int n;
        mode_chg = 1'b1;
        xcvr_ready = 1'b0;
        step(1);
        mode_chg = 1'b0;
        for (n = 0; n < 6 && mode_change_reset_o !== 1'b1; n++) step(1);
        chk_bit(mode_change_reset_o, 1'b1);
        step(1);
        chk_bit(mode_change_reset_o, 1'b0);
        chk_bit(xcvr_oe_o, 1'b0);
        xcvr_ready = 1'b1;
        for (n = 0; n < 6 && io_enable_o !== 1'b1; n++) step(1);
        chk_bit(io_enable_o, 1'b1);
    endtask
    // Enclosure warns of removal; drive quiesces its own I/O, then leaves.
    task automatic t_remove(input logic en);
        int n;
        spin_en = en;
        flush_en = en;
        io_idle = 1'b0;
        warn = 1'b1;
        for (n = 0; n < 40 && unmate_flag_o !== 1'b1; n++) step(1);
        chk_bit(n <= 20, 1'b1);
        chk_bit(io_enable_o, 1'b0);
        chk_bit(quiesce_req_o, 1'b1);
        step(1);
        chk_val({2'h0, spin_down_req_o, flush_req_o}, {2'h0, en, en});
        io_idle = 1'b1;
        step(2);
        chk_bit(quiesce_req_o, 1'b0);
        chk_bit(xcvr_oe_o, 1'b0);
        io_idle = 1'b0;
        warn = 1'b0;
        seat = 1'b0;
        step(12);
        chk_bit(mated_o, 1'b0);
    endtask
    // Reset held through a whole insertion and removal; no false mate on release.
    task automatic t_reset();
        resetn_i = 1'b0;
        seat = 1'b1;
        step(4);
        seat = 1'b0;
        step(12);
        chk_val({mated_o, unmate_flag_o, io_enable_o, xcvr_oe_o}, 4'h0);
        resetn_i = 1'b1;
        step(1);
        chk_bit(mated_o, 1'b0);
        step(1);
        chk_bit(mated_o, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        step(2);
        resetn_i = 1'b1;
        chk_val({mated_o, address_valid_o, io_enable_o, xcvr_oe_o}, 4'h0);
        t_glitch();
        t_insert(4'hf, 2'h3);
        t_mode();
        t_remove(1'b0);
        t_insert(4'h7, 2'h1);
        t_remove(1'b1);
        t_insert(4'h0, 2'h2);
        t_remove(1'b1);
        t_reset();
        t_insert(4'h9, 2'h0);
        end_sim();
    end
endmodule
`default_nettype wire
